//--- hw/dpsb_map.svh
`ifndef DPSB_MAP_SVH
`define DPSB_MAP_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define DPSB_AW 12
`define DPSB_DW 9
`define DPSB_MEM_BITS 4608
`define DPSB_IW 13

// ----------------------------------------------------------------
// Width selector codes and address masks
// ----------------------------------------------------------------
`define DPSB_WS_4KX1 2'h0
`define DPSB_WS_2KX2 2'h1
`define DPSB_WS_1KX4 2'h2
`define DPSB_WS_512X9 2'h3
`define DPSB_BITS_1 4'h1
`define DPSB_BITS_2 4'h2
`define DPSB_BITS_4 4'h4
`define DPSB_BITS_9 4'h9
`define DPSB_AMASK_4K 12'hFFF
`define DPSB_AMASK_2K 12'h7FF
`define DPSB_AMASK_1K 12'h3FF
`define DPSB_AMASK_512 12'h1FF

// ----------------------------------------------------------------
// Register map on the AHB-Lite slave
// ----------------------------------------------------------------
`define DPSB_REG_AW 8
`define DPSB_OFS_CTRL 8'h00
`define DPSB_OFS_STAT 8'h04
`define DPSB_CTRL_RST 8'h00
`define DPSB_HTRANS_NONSEQ 2'h2
`define DPSB_HTRANS_SEQ 2'h3
`define DPSB_OKAY 1'h0

// ----------------------------------------------------------------
// Synchroniser widths
// ----------------------------------------------------------------
`define DPSB_PIN_W 24
`define DPSB_RST_W 1

`endif

//--- hw/dpsb_pkg.sv
package dpsb_pkg;
  `include "dpsb_map.svh"

  // Pins of one port after synchronisation
  typedef struct packed {
    logic clk;
    logic sel_n;
    logic write_n;
    logic [`DPSB_AW-1:0] addr;
    logic [`DPSB_DW-1:0] wdata;
  } dpsb_pins_t;

  // Control register fields, bit 0 upward: ws_a, ws_b, pipe_a, pipe_b, wt_a, wt_b
  typedef struct packed {
    logic wt_b;
    logic wt_a;
    logic pipe_b;
    logic pipe_a;
    logic [1:0] ws_b;
    logic [1:0] ws_a;
  } dpsb_ctrl_t;

  // State of one port
  typedef struct packed {
    logic clk_d;
    logic [`DPSB_DW-1:0] pipe;
    logic [`DPSB_DW-1:0] dout;
  } dpsb_port_t;

  // Whole state of the top module
  typedef struct packed {
    logic [`DPSB_MEM_BITS-1:0] mem;
    dpsb_port_t pa;
    dpsb_port_t pb;
    dpsb_ctrl_t ctrl;
    logic wr_pend;
    logic rd_pend;
    logic [`DPSB_REG_AW-1:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } dpsb_state_t;
endpackage

//--- hw/dpsb_sync.sv
`timescale 1ns/100ps
module dpsb_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [W-1:0] din, // Asynchronous input
  output logic [W-1:0] dout // Synchronised output
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpsb_sync_st_t;

  dpsb_sync_st_t st_r;
  dpsb_sync_st_t st_nxt;

  // ----------------------------------------------------------------
  // Two-stage chain
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule

//--- hw/dpsb_top.sv
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// ----------------------------------------------------------------
// What this block does
// - Width selector 00/01/10/11 gives 4kx1, 2kx2, 1kx4, 512x9.
// - A port is accessed only while its select is low.
// - A deselected port holds its read data output.
// - Write enable low writes, high reads.
// - Each port runs on its own clock, independent or shared.
// - Without pipelining, read data appears in the cycle of the read.
// - With pipelining, read data is registered and appears one cycle later.
// - A write without write-through leaves the last read data on the output.
// - A write with write-through shows the written data on the output.
// - Write-through has no effect during reads.
// - Reset low zeroes outputs, blocks access and clears hold registers.
// - Reset low leaves the stored array contents unchanged; rst clears them.
// - Each port takes a 12-bit address for reads and writes.
// - Decoded address bits are [11:0], [10:0], [9:0] or [8:0] by width.
// ----------------------------------------------------------------
`include "dpsb_map.svh"
module dpsb_top
  import dpsb_pkg::*;
(
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic rst, // Async reset, active high
  input wire logic mem_reset_n, // Output reset pin, active low
  input wire logic port_a_clk, // Port A clock pin
  input wire logic port_a_select_n, // Port A select, active low
  input wire logic port_a_write_n, // Port A write enable, active low
  input wire logic [`DPSB_AW-1:0] port_a_addr, // Port A address
  input wire logic [`DPSB_DW-1:0] port_a_wdata, // Port A write data
  output logic [`DPSB_DW-1:0] port_a_rdata, // Port A read data
  input wire logic port_b_clk, // Port B clock pin
  input wire logic port_b_select_n, // Port B select, active low
  input wire logic port_b_write_n, // Port B write enable, active low
  input wire logic [`DPSB_AW-1:0] port_b_addr, // Port B address
  input wire logic [`DPSB_DW-1:0] port_b_wdata, // Port B write data
  output logic [`DPSB_DW-1:0] port_b_rdata, // Port B read data
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic hready, // AHB ready in
  input wire logic [31:0] hwdata, // AHB write data
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp // AHB response
);
  dpsb_state_t st_r;
  dpsb_state_t st_nxt;
  dpsb_pins_t pa_s;
  dpsb_pins_t pb_s;
  logic rstn_s;
  logic ev_a;
  logic ev_b;
  logic [`DPSB_DW-1:0] rd_a;
  logic [`DPSB_DW-1:0] rd_b;
  logic [`DPSB_DW-1:0] wd_a;
  logic [`DPSB_DW-1:0] wd_b;
  logic acc;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dpsb_sync #(.W(`DPSB_PIN_W)) u_sync_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({port_a_clk, port_a_select_n, port_a_write_n, port_a_addr, port_a_wdata}),
    .dout(pa_s)
  );

  dpsb_sync #(.W(`DPSB_PIN_W)) u_sync_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({port_b_clk, port_b_select_n, port_b_write_n, port_b_addr, port_b_wdata}),
    .dout(pb_s)
  );

  dpsb_sync #(.W(`DPSB_RST_W)) u_sync_rst (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(mem_reset_n),
    .dout(rstn_s)
  );

  // ----------------------------------------------------------------
  // Aspect ratio helpers
  // ----------------------------------------------------------------
  // Bits per word for a width code
  function automatic logic [3:0] width_of(logic [1:0] ws);
    case (ws)
      `DPSB_WS_2KX2: width_of = `DPSB_BITS_2;
      `DPSB_WS_1KX4: width_of = `DPSB_BITS_4;
      `DPSB_WS_512X9: width_of = `DPSB_BITS_9;
      default: width_of = `DPSB_BITS_1;
    endcase
  endfunction

  // First array bit of a word; high address bits outside the depth are ignored
  function automatic logic [`DPSB_IW-1:0] base_of(logic [`DPSB_AW-1:0] a, logic [1:0] ws);
    logic [`DPSB_AW-1:0] m;
    case (ws)
      `DPSB_WS_2KX2: m = `DPSB_AMASK_2K;
      `DPSB_WS_1KX4: m = `DPSB_AMASK_1K;
      `DPSB_WS_512X9: m = `DPSB_AMASK_512;
      default: m = `DPSB_AMASK_4K;
    endcase
    base_of = {1'b0, a & m} * {9'h000, width_of(ws)};
  endfunction

  // Zero data bits above the port width
  function automatic logic [`DPSB_DW-1:0] mask_data(logic [`DPSB_DW-1:0] d, logic [1:0] ws);
    mask_data = '0;
    for (int k = 0; k < `DPSB_DW; k++) begin
      if (k < int'(width_of(ws))) begin
        mask_data[k] = d[k];
      end
    end
  endfunction

  // Read one word
  function automatic logic [`DPSB_DW-1:0] read_word(logic [`DPSB_MEM_BITS-1:0] m,
                                                     logic [`DPSB_AW-1:0] a, logic [1:0] ws);
    logic [`DPSB_IW-1:0] b;
    b = base_of(a, ws);
    read_word = '0;
    for (int k = 0; k < `DPSB_DW; k++) begin
      if (k < int'(width_of(ws))) begin
        read_word[k] = m[b + `DPSB_IW'(k)];
      end
    end
  endfunction

  // Write one word into the array image
  function automatic logic [`DPSB_MEM_BITS-1:0] write_word(logic [`DPSB_MEM_BITS-1:0] m,
                                                            logic [`DPSB_AW-1:0] a,
                                                            logic [1:0] ws,
                                                            logic [`DPSB_DW-1:0] d);
    logic [`DPSB_IW-1:0] b;
    b = base_of(a, ws);
    write_word = m;
    for (int k = 0; k < `DPSB_DW; k++) begin
      if (k < int'(width_of(ws))) begin
        write_word[b + `DPSB_IW'(k)] = d[k];
      end
    end
  endfunction

  // Output path of one port at its clock edge
  function automatic dpsb_port_t port_step(dpsb_port_t p, dpsb_pins_t s, logic rstn, logic ev,
                                           logic pipe, logic wt, logic [`DPSB_DW-1:0] rd,
                                           logic [`DPSB_DW-1:0] wd);
    dpsb_port_t n;
    n = p;
    n.clk_d = s.clk;
    if (!rstn) begin
      n.pipe = '0;
      n.dout = '0;
    end else if (ev) begin
      if (s.write_n) begin
        // Read wins over write-through
        if (pipe) begin
          n.pipe = rd;
          n.dout = p.pipe;
        end else begin
          n.dout = rd;
        end
      end else if (wt) begin
        if (pipe) begin
          n.pipe = wd;
          n.dout = p.pipe;
        end else begin
          n.dout = wd;
        end
      end else if (pipe) begin
        n.dout = p.pipe;
      end
    end
    port_step = n;
  endfunction

  // ----------------------------------------------------------------
  // Port events and data
  // ----------------------------------------------------------------
  // Edge of a port clock while selected and out of reset
  assign ev_a = rstn_s && pa_s.clk && !st_r.pa.clk_d && !pa_s.sel_n;
  assign ev_b = rstn_s && pb_s.clk && !st_r.pb.clk_d && !pb_s.sel_n;
  assign rd_a = read_word(st_r.mem, pa_s.addr, st_r.ctrl.ws_a);
  assign rd_b = read_word(st_r.mem, pb_s.addr, st_r.ctrl.ws_b);
  assign wd_a = mask_data(pa_s.wdata, st_r.ctrl.ws_a);
  assign wd_b = mask_data(pb_s.wdata, st_r.ctrl.ws_b);
  assign acc = hsel && hready && (htrans == `DPSB_HTRANS_NONSEQ || htrans == `DPSB_HTRANS_SEQ);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Array writes; port B wins a same-word collision
    if (ev_a && !pa_s.write_n) begin
      st_nxt.mem = write_word(st_nxt.mem, pa_s.addr, st_r.ctrl.ws_a, wd_a);
    end
    if (ev_b && !pb_s.write_n) begin
      st_nxt.mem = write_word(st_nxt.mem, pb_s.addr, st_r.ctrl.ws_b, wd_b);
    end
    st_nxt.pa = port_step(st_r.pa, pa_s, rstn_s, ev_a, st_r.ctrl.pipe_a, st_r.ctrl.wt_a,
                          rd_a, wd_a);
    st_nxt.pb = port_step(st_r.pb, pb_s, rstn_s, ev_b, st_r.ctrl.pipe_b, st_r.ctrl.wt_b,
                          rd_b, wd_b);
    // Bus data phase of a write
    if (st_r.wr_pend && st_r.addr == `DPSB_OFS_CTRL) begin
      st_nxt.ctrl = dpsb_ctrl_t'(hwdata[$bits(dpsb_ctrl_t)-1:0]);
    end
    // Bus read: one wait state, then data
    st_nxt.hreadyout = 1'b1;
    if (st_r.rd_pend) begin
      case (st_r.addr)
        `DPSB_OFS_CTRL: st_nxt.hrdata = 32'(st_r.ctrl);
        `DPSB_OFS_STAT: st_nxt.hrdata = 32'({!rstn_s, st_r.pb.dout, st_r.pa.dout});
        default: st_nxt.hrdata = '0;
      endcase
    end
    st_nxt.wr_pend = acc && hwrite;
    st_nxt.rd_pend = acc && !hwrite;
    if (acc) begin
      st_nxt.addr = haddr[`DPSB_REG_AW-1:0];
      st_nxt.hreadyout = hwrite;
    end
    st_nxt.hresp = `DPSB_OKAY;
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '{mem: '0, pa: '0, pb: '0, ctrl: dpsb_ctrl_t'(`DPSB_CTRL_RST), wr_pend: 1'b0,
                rd_pend: 1'b0, addr: '0, hrdata: '0, hreadyout: 1'b1, hresp: `DPSB_OKAY};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign port_a_rdata = st_r.pa.dout;
  assign port_b_rdata = st_r.pb.dout;
  assign hrdata = st_r.hrdata;
  assign hreadyout = st_r.hreadyout;
  assign hresp = st_r.hresp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_desel_no_write;
    rstn_s && pa_s.sel_n && !ev_b |=> $stable(st_r.mem);
  endproperty
  a_desel_no_write: assert property (p_desel_no_write) else $error("deselected port changed array");

  property p_desel_hold;
    rstn_s && pa_s.sel_n |=> $stable(port_a_rdata);
  endproperty
  a_desel_hold: assert property (p_desel_hold) else $error("deselected port output moved");

  property p_flow_read;
    ev_a && pa_s.write_n && !st_r.ctrl.pipe_a |=> port_a_rdata == $past(rd_a);
  endproperty
  a_flow_read: assert property (p_flow_read) else $error("flow-through read data wrong");

  property p_pipe_read;
    ev_a && pa_s.write_n && st_r.ctrl.pipe_a
      |=> port_a_rdata == $past(st_r.pa.pipe) && st_r.pa.pipe == $past(rd_a);
  endproperty
  a_pipe_read: assert property (p_pipe_read) else $error("pipelined read data wrong");

  property p_write_keep;
    ev_a && !pa_s.write_n && !st_r.ctrl.wt_a && !st_r.ctrl.pipe_a |=> $stable(port_a_rdata);
  endproperty
  a_write_keep: assert property (p_write_keep) else $error("output moved on plain write");

  property p_write_thru;
    ev_a && !pa_s.write_n && st_r.ctrl.wt_a && !st_r.ctrl.pipe_a |=> port_a_rdata == $past(wd_a);
  endproperty
  a_write_thru: assert property (p_write_thru) else $error("write-through data missing");

  property p_rst_out;
    !rstn_s |=> port_a_rdata == '0 && port_b_rdata == '0 && st_r.pa.pipe == '0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared in reset");

  property p_rst_mem;
    !rstn_s |=> $stable(st_r.mem);
  endproperty
  a_rst_mem: assert property (p_rst_mem) else $error("array changed during reset");

  property p_commit;
    ev_a && !pa_s.write_n && !(ev_b && !pb_s.write_n)
      |=> read_word(st_r.mem, $past(pa_s.addr), $past(st_r.ctrl.ws_a)) == $past(wd_a);
  endproperty
  a_commit: assert property (p_commit) else $error("write not committed");

  property p_port_b_read;
    ev_b && pb_s.write_n && !st_r.ctrl.pipe_b |=> port_b_rdata == $past(rd_b);
  endproperty
  a_port_b_read: assert property (p_port_b_read) else $error("port B read data wrong");

  // Main scenarios
  c_pipe_read: cover property (ev_a && pa_s.write_n && st_r.ctrl.pipe_a);
  c_write_thru: cover property (ev_b && !pb_s.write_n && st_r.ctrl.wt_b);
  c_both_edges: cover property (ev_a && ev_b);
  c_wide_mode: cover property (ev_a && st_r.ctrl.ws_a == `DPSB_WS_512X9);
endmodule

//--- sim/dpsb_fabric_model.sv
`timescale 1ns/100ps
`include "dpsb_map.svh"
// ----------------------------------------------------------------
// Fabric logic driving one memory port
// ----------------------------------------------------------------
module dpsb_fabric_model
  import dpsb_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic go, // Start one port clock frame
  input wire logic sel_n, // Select level for the frame
  input wire logic wr_n, // Write enable level
  input wire logic [1:0] ws, // Width code of the port
  input wire logic [3:0] hold, // Cycles per clock phase, 4 or more
  input wire logic [`DPSB_AW-1:0] addr, // Frame address
  input wire logic [`DPSB_DW-1:0] wdata, // Frame write data
  output logic pclk, // Port clock pin
  output logic select_n, // Port select pin
  output logic write_n, // Port write enable pin
  output logic [`DPSB_AW-1:0] addr_o, // Port address pins
  output logic [`DPSB_DW-1:0] wdata_o, // Port write data pins
  output logic done // High one cycle at frame end
);
  logic [`DPSB_AW-1:0] amask;

  // Unused high address bits are held low for the depth in use
  always_comb begin
    case (ws)
      `DPSB_WS_4KX1: amask = `DPSB_AMASK_4K;
      `DPSB_WS_2KX2: amask = `DPSB_AMASK_2K;
      `DPSB_WS_1KX4: amask = `DPSB_AMASK_1K;
      default: amask = `DPSB_AMASK_512;
    endcase
  end

  initial begin
    pclk = 1'b0;
    select_n = 1'b1;
    write_n = 1'b1;
    addr_o = 12'h000;
    wdata_o = 9'h000;
    done = 1'b0;
  end

  // One frame: pins steady across the whole clock pulse, clock idle low
  always @(posedge clk_sys) begin
    if (go) begin
      select_n <= sel_n;
      write_n <= wr_n;
      addr_o <= addr & amask;
      wdata_o <= wdata;
      repeat (hold) @(posedge clk_sys);
      pclk <= 1'b1;
      repeat (hold) @(posedge clk_sys);
      pclk <= 1'b0;
      repeat (hold) @(posedge clk_sys);
      // Released lines wander so stale values are never trusted
      select_n <= 1'b1;
      write_n <= ~write_n;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
      done <= 1'b1;
      @(posedge clk_sys);
      done <= 1'b0;
    end
  end
endmodule

//--- sim/dpsb_top_test.sv
`timescale 1ns/100ps
`include "dpsb_map.svh"
module dpsb_top_test
  import dpsb_pkg::*;
  ;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mem_reset_n = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire [31:0] hrdata;
  wire hready;
  wire hreadyout;
  wire hresp;
  logic [1:0] go = 2'h0;
  logic [1:0] sel = 2'h0;
  logic [1:0] wr = 2'h3;
  logic [1:0] ws = 2'h0;
  logic [3:0] hold [2] = '{4'h4, 4'h6};
  logic [11:0] ad [2] = '{12'h0, 12'h0};
  logic [8:0] wd [2] = '{9'h0, 9'h0};
  logic [8:0] wm [4] = '{9'h001, 9'h003, 9'h00F, 9'h1FF};
  wire [1:0] pclk;
  wire [1:0] psn;
  wire [1:0] pwn;
  wire [1:0] done;
  wire [11:0] pad [2];
  wire [8:0] pwd [2];
  wire [8:0] rda;
  wire [8:0] rdb;
  int error_cnt = 0;
  int total_checks = 0;
  int waits = 0;

  assign hready = hreadyout;

  // ----------------------------------------------------------------
  // Clock, design and fabric models
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  dpsb_top i_dut (.clk_sys(clk_sys), .rst(rst), .mem_reset_n(mem_reset_n),
    .port_a_clk(pclk[0]), .port_a_select_n(psn[0]), .port_a_write_n(pwn[0]),
    .port_a_addr(pad[0]), .port_a_wdata(pwd[0]), .port_a_rdata(rda),
    .port_b_clk(pclk[1]), .port_b_select_n(psn[1]), .port_b_write_n(pwn[1]),
    .port_b_addr(pad[1]), .port_b_wdata(pwd[1]), .port_b_rdata(rdb),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  dpsb_fabric_model i_fab_a (.clk_sys(clk_sys), .go(go[0]), .sel_n(sel[0]),
    .wr_n(wr[0]), .ws(ws), .hold(hold[0]), .addr(ad[0]), .wdata(wd[0]), .pclk(pclk[0]),
    .select_n(psn[0]), .write_n(pwn[0]), .addr_o(pad[0]), .wdata_o(pwd[0]), .done(done[0]));

  dpsb_fabric_model i_fab_b (.clk_sys(clk_sys), .go(go[1]), .sel_n(sel[1]),
    .wr_n(wr[1]), .ws(ws), .hold(hold[1]), .addr(ad[1]), .wdata(wd[1]), .pclk(pclk[1]),
    .select_n(psn[1]), .write_n(pwn[1]), .addr_o(pad[1]), .wdata_o(pwd[1]), .done(done[1]));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for hready high at a rising edge; only the watchdog ends a hang
  task automatic wait_rdy();
    @(posedge clk_sys);
    while (hready !== 1'b1) begin
      @(posedge clk_sys);
      waits++;
    end
  endtask

  // Single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= `DPSB_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    waits = 0;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(waits, 32'h1);
  endtask

  task automatic wctl(input logic [31:0] d);
    logic [31:0] r;
    waits = 0;
    ahb(1'b1, 32'h0, d, r);
    chk(waits, 32'h0);
  endtask

  // One port frame on port p, waits for its end
  task automatic pop(input int p, input logic s, input logic w, input logic [11:0] a,
                     input logic [8:0] d);
    go[p] <= 1'b1;
    sel[p] <= s;
    wr[p] <= w;
    ad[p] <= a;
    wd[p] <= d;
    @(posedge clk_sys);
    go[p] <= 1'b0;
    while (done[p] !== 1'b1) begin
      @(posedge clk_sys);
    end
  endtask

  task automatic prd(input int p, input logic [11:0] a, input logic [31:0] e);
    pop(p, 1'b0, 1'b1, a, 9'h000);
    chk(p ? rdb : rda, e);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(rda, 32'h0);
    chk(hresp, 32'h0);
    rd_chk(`DPSB_OFS_CTRL, 32'h0);
    rd_chk(`DPSB_OFS_STAT, 32'h0);
    rd_chk(32'h10, 32'h0);
    wctl(32'hFF);
    rd_chk(`DPSB_OFS_CTRL, 32'hFF);
    $display("test registers done");
    // Every width code: top address and address 0, written and read across ports
    for (int k = 0; k < 4; k++) begin
      ws <= k[1:0];
      wctl(32'(k) * 32'h5);
      pop(0, 1'b0, 1'b0, 12'hFFF >> k, 9'h1A5);
      pop(1, 1'b0, 1'b0, 12'h000, 9'h05A);
      prd(1, 12'hFFF >> k, 32'(9'h1A5 & wm[k]));
      prd(0, 12'h000, 32'(9'h05A & wm[k]));
    end
    $display("test widths done");
    prd(0, 12'h000, 32'h5A);
    pop(0, 1'b1, 1'b1, 12'h1FF, 9'h000);
    chk(rda, 32'h5A);
    pop(0, 1'b1, 1'b0, 12'h000, 9'h0C3);
    prd(0, 12'h000, 32'h5A);
    $display("test select done");
    wctl(32'hCF);
    pop(0, 1'b0, 1'b0, 12'h005, 9'h0F3);
    chk(rda, 32'hF3);
    pop(1, 1'b0, 1'b0, 12'h006, 9'h0C3);
    chk(rdb, 32'hC3);
    prd(0, 12'h000, 32'h5A);
    wctl(32'h0F);
    pop(0, 1'b0, 1'b0, 12'h005, 9'h11E);
    chk(rda, 32'h5A);
    prd(0, 12'h005, 32'h11E);
    $display("test write modes done");
    // Both ports in the same cycle on one word: port B wins
    hold[1] <= 4'h4;
    sel <= 2'h0;
    wr <= 2'h0;
    ad <= '{12'h007, 12'h007};
    wd <= '{9'h0E1, 9'h01E};
    go <= 2'h3;
    @(posedge clk_sys);
    go <= 2'h0;
    while (done !== 2'h3) begin
      @(posedge clk_sys);
    end
    prd(0, 12'h007, 32'h01E);
    $display("test both ports done");
    wctl(32'h3F);
    pop(0, 1'b0, 1'b1, 12'h000, 9'h000);
    prd(0, 12'h005, 32'h5A);
    prd(0, 12'h005, 32'h11E);
    prd(1, 12'h005, 32'h0);
    prd(1, 12'h006, 32'h11E);
    $display("test pipeline done");
    wctl(32'h0F);
    mem_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(rda, 32'h0);
    chk(rdb, 32'h0);
    rd_chk(`DPSB_OFS_STAT, 32'h40000);
    pop(0, 1'b0, 1'b0, 12'h005, 9'h0AA);
    mem_reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    prd(1, 12'h005, 32'h11E);
    $display("test memory reset done");
    wrap_up();
  end
endmodule
